// ===== dv/lgp_pin_model.sv
// outside world of the shared pins: pull-ups plus optional outside drivers
// assumes oe_n low means the block drives the pin
`timescale 1ns/100ps
module lgp_pin_model (
	input wire logic [7:0] i_pin_out,
	input wire logic [7:0] i_pin_oe_n,
	input wire logic [7:0] i_ext_val,
	input wire logic [7:0] i_ext_en,
	output logic [7:0] o_wire
);
	// ------------------------------
	// wire resolution
	// ------------------------------
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (!i_pin_oe_n[i]) begin
				o_wire[i] = i_pin_out[i];
			end else if (i_ext_en[i]) begin
				o_wire[i] = i_ext_val[i];
			end else begin
				o_wire[i] = 1'h1;
			end
		end
	end
endmodule

// ===== dv/testbench.sv
// self-checking bench for the led / gpio pin block
// assumes the pin model stands on the shared pins; inputs change at falling edges
`timescale 1ns/100ps
module testbench;
	import lgp_pkg::*;
	logic clk = 1'h0, rstn = 1'h0, wr = 1'h0, rd = 1'h0, irq;
	logic [7:0] addr = 8'h00, wdata = 8'h00, en = 8'h00, clr = 8'h00, ext_v = 8'h00;
	logic [7:0] ext_en = 8'h00, rdata, pout, poe_n, flag, pin;
	logic [10:0] pol = 11'h000, link = 11'h000, sens = 11'h000;
	logic [2:0] lout, loe_n;
	logic [7:0] regs [5] = '{8'h70, 8'h71, 8'h73, 8'h74, 8'h75};
	int err_count = 0, n_checks = 0;

	lgp_pin_ctrl dut (.i_ref_clk(clk), .i_resetn(rstn), .i_reg_addr(addr), .i_reg_wr(wr),
		.i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_lamp_invert_sel(pol),
		.i_link_en(link), .i_sensor_active(sens), .i_change_int_en(en),
		.i_change_flag_clr(clr), .i_pin_level(pin), .o_pin_out(pout), .o_pin_oe_n(poe_n),
		.o_lamp_out(lout), .o_lamp_oe_n(loe_n), .o_pin_change_flag(flag), .o_int(irq));
	lgp_pin_model pins (.i_pin_out(pout), .i_pin_oe_n(poe_n), .i_ext_val(ext_v),
		.i_ext_en(ext_en), .o_wire(pin));

	// ------------------------------
	// tasks
	// ------------------------------
	task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr = 1'h1;
		@(negedge clk);
		wr = 1'h0;
	endtask
	// rdata stands one cycle only, so it is sampled at the very next falling edge
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk);
		addr = a;
		rd = 1'h1;
		@(negedge clk);
		rd = 1'h0;
		chk(rdata, exp);
	endtask
	task automatic test_done();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// ------------------------------
	// clock, watchdog, tests
	// ------------------------------
	initial begin
		forever #20 clk = ~clk;
	end
	initial begin
		#(40 * 3000);
		err_count++;
		test_done();
	end
	initial begin
		idle(10);
		rstn = 1'h1;
		foreach (regs[i]) begin
			rd_chk(regs[i], 8'h00);
		end
		chk(flag, 8'h00);
		chk(poe_n, 8'hFF);
		wr_reg(8'h70, 8'hFF);
		rd_chk(8'h70, 8'hFF);
		wr_reg(8'h74, 8'hFF);
		rd_chk(8'h74, 8'h07);
		wr_reg(8'h71, 8'h0F);
		wr_reg(8'h73, 8'h55);
		wr_reg(8'h72, 8'h00);
		idle(2);
		chk(pout, 8'h0A);
		chk(poe_n, 8'hA0);
		idle(3);
		rd_chk(8'h72, 8'hAA);
		pol = 11'h7FF;
		idle(3);
		chk(pout, 8'h05);
		chk(poe_n, 8'h50);
		chk(loe_n, 3'h7);
		pol = 11'h000;
		idle(3);
		chk(loe_n, 3'h0);
		chk(lout, 3'h0);
		wr_reg(8'h74, 8'h00);
		idle(2);
		chk(loe_n, 3'h7);
		link = 11'h200;
		sens = 11'h100;
		idle(3);
		chk(loe_n, 3'h6);
		link = 11'h480;
		sens = 11'h480;
		idle(3);
		chk(loe_n, 3'h7);
		chk(poe_n, 8'hA0);
		wr_reg(8'h70, 8'h00);
		idle(2);
		chk(poe_n, 8'hFF);
		chk(pout, 8'h00);
		idle(4);
		clr = 8'hFF;
		idle(1);
		clr = 8'h00;
		en = 8'h10;
		ext_en = 8'h20;
		idle(6);
		chk(flag, 8'h20);
		chk(irq, 1'h0);
		ext_en = 8'h30;
		idle(6);
		chk(irq, 1'h1);
		clr = 8'h10;
		idle(1);
		clr = 8'h00;
		idle(2);
		chk(flag, 8'h20);
		chk(irq, 1'h0);
		wr_reg(8'h71, 8'h01);
		wr_reg(8'h70, 8'h01);
		idle(6);
		rd_chk(8'h72, 8'hCE);
		chk(flag, 8'h20);
		// reset in mid-run: pin 0 is released, pins 4 and 5 stay held low outside
		rstn = 1'h0;
		idle(2);
		rstn = 1'h1;
		idle(6);
		chk(flag, 8'h00);
		chk(irq, 1'h0);
		chk(loe_n, 3'h7);
		rd_chk(8'h70, 8'h00);
		rd_chk(8'h72, 8'hCF);
		test_done();
	end
endmodule

// ===== logic/lgp_pin_ctrl.sv
// direction, output type, input level and actuate control of the led / gpio pins
// assumes a byte register port driven by the host serial engine, one access per cycle
`timescale 1ns/100ps
module lgp_pin_ctrl
	import lgp_pkg::*;
#(
	parameter int PINS = LGP_SHARED_PINS
) (
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	input wire logic [7:0] i_reg_addr,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [7:0] i_reg_wdata,
	output logic [7:0] o_reg_rdata,
	input wire logic [LGP_LAMPS-1:0] i_lamp_invert_sel,
	input wire logic [LGP_LAMPS-1:0] i_link_en,
	input wire logic [LGP_LAMPS-1:0] i_sensor_active,
	input wire logic [PINS-1:0] i_change_int_en,
	input wire logic [PINS-1:0] i_change_flag_clr,
	input wire logic [PINS-1:0] i_pin_level,
	output logic [PINS-1:0] o_pin_out,
	output logic [PINS-1:0] o_pin_oe_n,
	output logic [LGP_LAMP_ONLY-1:0] o_lamp_out,
	output logic [LGP_LAMP_ONLY-1:0] o_lamp_oe_n,
	output logic [PINS-1:0] o_pin_change_flag,
	output logic o_int
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [PINS-1:0] pin_dir_bit;
		logic [PINS-1:0] pin_drive_type_bit;
		logic [PINS-1:0] pin_level_bit;
		logic [PINS-1:0] act_lo;
		logic [LGP_LAMP_ONLY-1:0] act_hi;
		logic [PINS-1:0] pin_change_flag;
		logic irq;
		logic [PINS-1:0] pin_out;
		logic [PINS-1:0] pin_oe_n;
		logic [LGP_LAMP_ONLY-1:0] lamp_out;
		logic [LGP_LAMP_ONLY-1:0] lamp_oe_n;
		logic [7:0] rdata;
		logic [LGP_SYNC_STAGES:0] sync_warm;
	} lgp_state_type;

	lgp_state_type s_ff;
	lgp_state_type nxt_s;
	logic [PINS-1:0] lvl_sync;
	logic [PINS-1:0] chg;
	logic [LGP_LAMPS-1:0] link_eff;
	logic [LGP_LAMPS-1:0] lamp_actuate_bit;
	logic [LGP_LAMPS-1:0] lamp_level;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic hit(input logic [7:0] a, input logic [7:0] base);
		hit = (a == base);
	endfunction

	// ----------------------------------------
	// pin level synchroniser
	// ----------------------------------------
	lgp_sync #(
		.WIDTH(PINS)
	) u_sync (
		.i_ref_clk(i_ref_clk),
		.i_resetn(i_resetn),
		.i_async(i_pin_level),
		.o_sync(lvl_sync)
	);

	// ----------------------------------------
	// actuation and pin level
	// ----------------------------------------
	always_comb begin
		link_eff = i_link_en;
		link_eff[LGP_LAMP8_IDX] = 1'b0;
		link_eff[LGP_LAMP11_IDX] = 1'b0;
		// group link on lamp 10 drags lamp 9 along
		link_eff[LGP_LAMP9_IDX] = i_link_en[LGP_LAMP9_IDX] | i_link_en[LGP_LAMP10_IDX];
		// a linked touch counts the same as a set actuate bit
		lamp_actuate_bit = {s_ff.act_hi, s_ff.act_lo} | (link_eff & i_sensor_active);
		// actuated level is the polarity bit, idle level its inverse
		lamp_level = ~(lamp_actuate_bit ^ i_lamp_invert_sel);
	end

	// blind until the level register holds a real pin value, else reset looks like an edge
	assign chg = (lvl_sync ^ s_ff.pin_level_bit) & ~s_ff.pin_dir_bit
		& {PINS{s_ff.sync_warm[LGP_SYNC_STAGES]}};

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		nxt_s = s_ff;
		if (i_reg_wr) begin
			if (hit(i_reg_addr, LGP_ADDR_DIR)) begin
				nxt_s.pin_dir_bit = i_reg_wdata[PINS-1:0];
			end
			if (hit(i_reg_addr, LGP_ADDR_OTYPE)) begin
				nxt_s.pin_drive_type_bit = i_reg_wdata[PINS-1:0];
			end
			if (hit(i_reg_addr, LGP_ADDR_ACT_LO)) begin
				nxt_s.act_lo = i_reg_wdata[PINS-1:0];
			end
			if (hit(i_reg_addr, LGP_ADDR_ACT_HI)) begin
				nxt_s.act_hi = i_reg_wdata[LGP_LAMP_ONLY-1:0];
			end
		end
		// input register follows the pin even when it is driven
		nxt_s.pin_level_bit = lvl_sync;
		// fills with ones as the synchroniser and level register load after reset
		nxt_s.sync_warm = {s_ff.sync_warm[LGP_SYNC_STAGES-1:0], 1'b1};
		// set beats a clear in the same cycle
		nxt_s.pin_change_flag = (s_ff.pin_change_flag & ~i_change_flag_clr) | chg;
		nxt_s.irq = |(nxt_s.pin_change_flag & i_change_int_en);
		for (int i = 0; i < PINS; i++) begin
			if (!s_ff.pin_dir_bit[i]) begin
				// input pins never drive, type ignored
				nxt_s.pin_out[i] = 1'b0;
				nxt_s.pin_oe_n[i] = 1'b1;
			end else if (s_ff.pin_drive_type_bit[i]) begin
				nxt_s.pin_out[i] = lamp_level[i];
				nxt_s.pin_oe_n[i] = 1'b0;
			end else begin
				// open-drain: only a low is driven
				nxt_s.pin_out[i] = 1'b0;
				nxt_s.pin_oe_n[i] = lamp_level[i];
			end
		end
		// led-only outputs are low-side sinks, hence open-drain
		for (int j = 0; j < LGP_LAMP_ONLY; j++) begin
			nxt_s.lamp_out[j] = 1'b0;
			nxt_s.lamp_oe_n[j] = lamp_level[PINS+j];
		end
		nxt_s.rdata = LGP_RDATA_IDLE;
		if (i_reg_rd) begin
			case (i_reg_addr)
				LGP_ADDR_DIR: begin
					nxt_s.rdata = s_ff.pin_dir_bit;
				end
				LGP_ADDR_OTYPE: begin
					nxt_s.rdata = s_ff.pin_drive_type_bit;
				end
				LGP_ADDR_LEVEL: begin
					nxt_s.rdata = s_ff.pin_level_bit;
				end
				LGP_ADDR_ACT_LO: begin
					nxt_s.rdata = s_ff.act_lo;
				end
				LGP_ADDR_ACT_HI: begin
					nxt_s.rdata = {5'h00, s_ff.act_hi};
				end
				default: begin
					nxt_s.rdata = LGP_RDATA_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			s_ff.pin_dir_bit <= LGP_RST_BYTE;
			s_ff.pin_drive_type_bit <= LGP_RST_BYTE;
			s_ff.pin_level_bit <= LGP_RST_BYTE;
			s_ff.act_lo <= LGP_RST_BYTE;
			s_ff.act_hi <= LGP_RST_HI;
			s_ff.pin_change_flag <= '0;
			s_ff.irq <= 1'b0;
			s_ff.pin_out <= '0;
			s_ff.pin_oe_n <= '1;
			s_ff.lamp_out <= '0;
			s_ff.lamp_oe_n <= '1;
			s_ff.rdata <= LGP_RDATA_IDLE;
			s_ff.sync_warm <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign o_reg_rdata = s_ff.rdata;
	assign o_pin_out = s_ff.pin_out;
	assign o_pin_oe_n = s_ff.pin_oe_n;
	assign o_lamp_out = s_ff.lamp_out;
	assign o_lamp_oe_n = s_ff.lamp_oe_n;
	assign o_pin_change_flag = s_ff.pin_change_flag;
	assign o_int = s_ff.irq;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_resetn);

	sequence s_dir_write;
		i_reg_wr && i_reg_addr == LGP_ADDR_DIR;
	endsequence

	sequence s_pin_quiet;
		$stable(i_pin_level) [*4];
	endsequence

	property p_input_released;
		s_dir_write ##1 1'b1 |=> (~$past(s_ff.pin_dir_bit) & ~o_pin_oe_n) == '0;
	endproperty
	a_input_released: assert property (p_input_released) else $error("input pin driven");

	property p_dir_readback;
		s_dir_write |=> s_ff.pin_dir_bit == $past(i_reg_wdata);
	endproperty
	a_dir_readback: assert property (p_dir_readback) else $error("direction not stored");

	property p_push_pull;
		1'b1 |=> ($past(s_ff.pin_dir_bit & s_ff.pin_drive_type_bit) & o_pin_oe_n) == '0;
	endproperty
	a_push_pull: assert property (p_push_pull) else $error("push-pull pin released");

	property p_open_drain_low;
		1'b1 |=> ($past(s_ff.pin_dir_bit & ~s_ff.pin_drive_type_bit) & o_pin_out) == '0;
	endproperty
	a_open_drain_low: assert property (p_open_drain_low) else $error("open-drain drove high");

	property p_level_follows;
		s_pin_quiet |-> s_ff.pin_level_bit == $past(i_pin_level, 3);
	endproperty
	a_level_follows: assert property (p_level_follows) else $error("level register stale");

	property p_change_sets;
		chg != '0 |=> (s_ff.pin_change_flag & $past(chg)) == $past(chg);
	endproperty
	a_change_sets: assert property (p_change_sets) else $error("change flag missed");

	property p_irq;
		1'b1 |=> o_int == |($past(nxt_s.pin_change_flag) & $past(i_change_int_en));
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt mismatch");

	property p_hi_upper_zero;
		i_reg_rd && i_reg_addr == LGP_ADDR_ACT_HI |=> o_reg_rdata[7:3] == 5'h00;
	endproperty
	a_hi_upper_zero: assert property (p_hi_upper_zero) else $error("upper bits not zero");

	property p_input_out_low;
		1'b1 |=> (~$past(s_ff.pin_dir_bit) & o_pin_out) == '0;
	endproperty
	a_input_out_low: assert property (p_input_out_low) else $error("input pin value set");

	property p_level_read;
		i_reg_rd && i_reg_addr == LGP_ADDR_LEVEL |=> o_reg_rdata == $past(s_ff.pin_level_bit);
	endproperty
	a_level_read: assert property (p_level_read) else $error("level read wrong");

	property p_output_no_flag;
		1'b1 |=> ($past(s_ff.pin_dir_bit) & o_pin_change_flag
			& ~$past(s_ff.pin_change_flag)) == '0;
	endproperty
	a_output_no_flag: assert property (p_output_no_flag) else $error("output pin flagged");

	property p_warm_quiet;
		!s_ff.sync_warm[LGP_SYNC_STAGES] |=> o_pin_change_flag == '0;
	endproperty
	a_warm_quiet: assert property (p_warm_quiet) else $error("flag set by reset");

	property p_lamp11_direct;
		1'b1 |=> o_lamp_oe_n[LGP_LAMP11_IDX-LGP_SHARED_PINS]
			== $past(~(s_ff.act_hi[LGP_LAMP11_IDX-LGP_SHARED_PINS]
			^ i_lamp_invert_sel[LGP_LAMP11_IDX]));
	endproperty
	a_lamp11_direct: assert property (p_lamp11_direct) else $error("lamp 11 linked");

	property p_lamp9_linked;
		i_link_en[LGP_LAMP10_IDX] && i_sensor_active[LGP_LAMP9_IDX]
			&& !i_lamp_invert_sel[LGP_LAMP9_IDX] |=> !o_lamp_oe_n[LGP_LAMP9_IDX-LGP_SHARED_PINS];
	endproperty
	a_lamp9_linked: assert property (p_lamp9_linked) else $error("lamp 9 not linked");

	property p_lamp_inverted;
		s_ff.act_hi[LGP_LAMP9_IDX-LGP_SHARED_PINS] && !i_lamp_invert_sel[LGP_LAMP9_IDX]
			|=> !o_lamp_oe_n[LGP_LAMP9_IDX-LGP_SHARED_PINS];
	endproperty
	a_lamp_inverted: assert property (p_lamp_inverted) else $error("inverted lamp not low");

endmodule

// ===== logic/lgp_pkg.sv
// register map, reset values and field sizes of the led / gpio pin block
// assumes one 25 MHz clock; the register port is a plain byte access port
package lgp_pkg;

	// ----------------------------------------
	// sizes
	// ----------------------------------------
	localparam int LGP_SHARED_PINS = 8;
	localparam int LGP_LAMP_ONLY = 3;
	localparam int LGP_LAMPS = 11;
	localparam int LGP_SYNC_STAGES = 2;

	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] LGP_ADDR_DIR = 8'h70;
	localparam logic [7:0] LGP_ADDR_OTYPE = 8'h71;
	localparam logic [7:0] LGP_ADDR_LEVEL = 8'h72;
	localparam logic [7:0] LGP_ADDR_ACT_LO = 8'h73;
	localparam logic [7:0] LGP_ADDR_ACT_HI = 8'h74;

	// ----------------------------------------
	// reset values and field positions
	// ----------------------------------------
	localparam logic [7:0] LGP_RST_BYTE = 8'h00;
	localparam logic [2:0] LGP_RST_HI = 3'h0;
	localparam logic [7:0] LGP_RDATA_IDLE = 8'h00;
	localparam int LGP_LAMP8_IDX = 7;
	localparam int LGP_LAMP9_IDX = 8;
	localparam int LGP_LAMP10_IDX = 9;
	localparam int LGP_LAMP11_IDX = 10;

endpackage

// ===== logic/lgp_sync.sv
// two-stage level synchroniser for a bus of pin levels
// assumes the pins are asynchronous to i_ref_clk; bits are synced independently
`timescale 1ns/100ps
module lgp_sync #(
	parameter int WIDTH = 8
) (
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;

	// ----------------------------------------
	// stages
	// ----------------------------------------
	// first stage is read only by the second
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= i_async;
			sync_ff <= meta_ff;
		end
	end

	assign o_sync = sync_ff;

endmodule
